/* rtl/irq_priority_enc.sv */
// Purpose: Picks the lowest-numbered pending interrupt source.
// Assumes: Requests are already gated by their enables.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module irq_priority_enc #(
   parameter int N = 34
) (
   input wire logic [N-1:0] req,
   vector_req_if.enc pick
);
   if (N < 1 || N > 63) begin : g_bad_n
      $error("irq_priority_enc: N out of range");
   end
   always_comb begin
      pick.any = 1'b0;
      pick.index = 6'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick.any = 1'b1;
            pick.index = 6'(i);
         end
      end
   end
endmodule : irq_priority_enc
`default_nettype wire

/* rtl/reset_irq_vector_mapper.sv */
// Purpose: Maps reset and interrupt sources to program-memory vectors.
// Assumes: Fuses are static after reset; requests come from core logic.
// Notes: Outputs are registered, so a pick appears one cycle later.
`timescale 1ns/1ps
`default_nettype none
module reset_irq_vector_mapper #(
   parameter int NUM_SRC = vector_map_pkg::NUM_SRC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic boot_reset_fuse,
   input wire logic vector_table_boot_select,
   input wire logic legacy_mode,
   input wire logic [15:0] boot_reset_addr,
   input wire logic reset_fetch_req,
   input wire logic [NUM_SRC-1:0] irq_pending,
   output logic vec_valid,
   output logic vec_is_reset,
   output logic [5:0] vec_number,
   output logic [15:0] vec_addr
);
   if (NUM_SRC != vector_map_pkg::NUM_SRC) begin : g_bad_count
      $error("reset_irq_vector_mapper: source count fixed by table");
   end

   logic [NUM_SRC-1:0] req_gated;
   logic vec_valid_q, vec_valid_d;
   logic vec_is_reset_q, vec_is_reset_d;
   logic [5:0] vec_number_q, vec_number_d;
   logic [15:0] vec_addr_q, vec_addr_d;
   logic [15:0] reset_target;
   logic [15:0] table_start;
   vector_req_if pick ();

   // Source index i maps to address 0x0002 + 2i; indices 0..7 are the
   // external lines, 8..15 timers, 16..22 serial and analog, 23..33 upper.
   always_comb begin
      for (int i = 0; i < NUM_SRC; i++) begin
         // Upper vectors are masked before arbitration in legacy mode.
         if (legacy_mode && (vector_map_pkg::TABLE_BASE
               + 16'(i) * vector_map_pkg::VEC_STRIDE)
               >= vector_map_pkg::LEGACY_LO) begin
            req_gated[i] = 1'b0;
         end else begin
            req_gated[i] = irq_pending[i];
         end
      end
   end

   irq_priority_enc #(.N(NUM_SRC)) u_enc (
      .req(req_gated),
      .pick(pick)
   );

   always_comb begin
      if (boot_reset_fuse == vector_map_pkg::FUSE_PROGRAMMED) begin
         reset_target = boot_reset_addr;
      end else begin
         reset_target = vector_map_pkg::RESET_ADDR;
      end
      if (vector_table_boot_select) begin
         table_start = boot_reset_addr + vector_map_pkg::TABLE_BASE;
      end else begin
         table_start = vector_map_pkg::TABLE_BASE;
      end
   end

   always_comb begin
      vec_valid_d = 1'b0;
      vec_is_reset_d = 1'b0;
      vec_number_d = 6'h00;
      vec_addr_d = 16'h0000;
      if (rst || reset_fetch_req) begin
         vec_valid_d = 1'b1;
         vec_is_reset_d = 1'b1;
         vec_number_d = vector_map_pkg::RESET_VEC;
         vec_addr_d = reset_target;
      end else if (pick.any) begin
         vec_valid_d = 1'b1;
         vec_number_d = vector_map_pkg::FIRST_IRQ_VEC + pick.index;
         vec_addr_d = table_start
            + 16'({10'h000, pick.index} * vector_map_pkg::VEC_STRIDE);
      end
   end

   always_ff @(posedge clk) begin
      vec_valid_q <= vec_valid_d;
      vec_is_reset_q <= vec_is_reset_d;
      vec_number_q <= vec_number_d;
      vec_addr_q <= vec_addr_d;
   end

   assign vec_valid = vec_valid_q;
   assign vec_is_reset = vec_is_reset_q;
   assign vec_number = vec_number_q;
   assign vec_addr = vec_addr_q;

   // Each check looks one cycle after its inputs, matching the output flops.
   a_reset_vector_addr: assert property (
      @(posedge clk) disable iff (rst)
      (reset_fetch_req && boot_reset_fuse) |=> (vec_addr == 16'h0000
      && vec_number == 6'h01 && vec_is_reset))
      else $error("reset vector not at zero");
   a_reset_during: assert property (
      @(posedge clk)
      rst |=> (vec_valid && vec_is_reset && vec_number == 6'h01))
      else $error("reset vector missing during reset");
   a_reset_wins: assert property (
      @(posedge clk) disable iff (rst)
      reset_fetch_req |=> (vec_valid && vec_is_reset
      && vec_number == 6'h01))
      else $error("request beat the reset vector");
   a_ext_irq_map: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[0] && !vector_table_boot_select)
      |=> (vec_addr == 16'h0002 && vec_number == 6'h02))
      else $error("line zero vector wrong");
   a_ext_last: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[7:0] == 8'h80
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0010 && vec_number == 6'd9))
      else $error("line seven vector wrong");
   a_addr_stride: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && !vector_table_boot_select) |=> (!vec_valid
      || vec_addr == ({10'h000, vec_number} << 1) - 16'h0002))
      else $error("vector address off its two-word stride");
   a_timer_first: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[8:0] == 9'h100
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0012 && vec_number == 6'd10))
      else $error("first timer vector wrong");
   a_timer_map: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[15:0] == 16'h8000
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0020 && vec_number == 6'd17))
      else $error("timer vector wrong");
   a_spi_first: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[16:0] == 17'h10000
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0022 && vec_number == 6'd18))
      else $error("transfer done vector wrong");
   a_comp_map: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[22:0] == 23'h400000
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h002e && vec_number == 6'd24))
      else $error("comparator vector wrong");
   a_upper_first: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[23:0] == 24'h800000 && !legacy_mode
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0030 && vec_number == 6'd25))
      else $error("first upper vector wrong");
   a_store_map: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending == 34'h200000000 && !legacy_mode
      && !vector_table_boot_select)
      |=> (vec_addr == 16'h0044 && vec_number == 6'd35))
      else $error("store vector wrong");
   a_boot_reset: assert property (
      @(posedge clk) disable iff (rst)
      (reset_fetch_req && !boot_reset_fuse)
      |=> (vec_addr == $past(boot_reset_addr)))
      else $error("boot reset address not used");
   a_table_moved: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[0] && vector_table_boot_select)
      |=> (vec_addr == $past(boot_reset_addr) + 16'h0002))
      else $error("table not moved to boot");
   a_table_last: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending == 34'h200000000 && !legacy_mode
      && vector_table_boot_select)
      |=> (vec_addr == $past(boot_reset_addr) + 16'h0044))
      else $error("moved store vector wrong");
   a_legacy_gap: assert property (
      @(posedge clk) disable iff (rst)
      (legacy_mode && !reset_fetch_req) |=>
      !(vec_valid && vec_number >= 6'd25))
      else $error("legacy vector fetched");
   a_legacy_first: assert property (
      @(posedge clk) disable iff (rst)
      (legacy_mode && !reset_fetch_req
      && irq_pending == 34'h000800000) |=> !vec_valid)
      else $error("masked source fetched in legacy mode");
   a_legacy_keeps: assert property (
      @(posedge clk) disable iff (rst)
      (legacy_mode && !reset_fetch_req && irq_pending[22:0] != 23'h000000)
      |=> (vec_valid && vec_number <= 6'd24))
      else $error("legacy mode lost a lower vector");
   a_boot_both: assert property (
      @(posedge clk) disable iff (rst)
      (reset_fetch_req && !boot_reset_fuse && vector_table_boot_select)
      |=> (vec_addr == $past(boot_reset_addr) && vec_number == 6'h01))
      else $error("reset moved by the select bit");
   a_fuse_polarity: assert property (
      @(posedge clk) disable iff (rst)
      (reset_fetch_req && boot_reset_fuse && boot_reset_addr != 16'h0000)
      |=> (vec_addr != $past(boot_reset_addr)))
      else $error("unprogrammed fuse used the boot address");
   a_idle_quiet: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending == '0) |=> !vec_valid)
      else $error("vector fetched while idle");
   a_lowest_wins: assert property (
      @(posedge clk) disable iff (rst)
      (!reset_fetch_req && irq_pending[0] && irq_pending[1])
      |=> vec_number == 6'h02)
      else $error("priority order wrong");
endmodule : reset_irq_vector_mapper
`default_nettype wire

/* rtl/vector_map_pkg.sv */
// Purpose: Constants for the reset and interrupt vector mapper.
// Assumes: Program-memory word addresses of 16 bits.
// Notes: Vector numbers count from one, reset being vector one.
package vector_map_pkg;
   localparam int ADDR_W = 16;
   localparam int NUM_SRC = 34;
   localparam int VEC_W = 6;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   localparam logic [15:0] TABLE_BASE = 16'h0002;
   localparam logic [15:0] VEC_STRIDE = 16'h0002;
   localparam logic [15:0] LEGACY_LO = 16'h0030;
   localparam logic [15:0] LEGACY_HI = 16'h0044;
   localparam logic [5:0] RESET_VEC = 6'h01;
   localparam logic [5:0] FIRST_IRQ_VEC = 6'h02;
   localparam logic FUSE_PROGRAMMED = 1'b0;
   localparam logic [15:0] BOOT_ADDR_DEFAULT = 16'hf000;
endpackage : vector_map_pkg

/* rtl/vector_req_if.sv */
// Purpose: Carries the priority pick between the encoder and the mapper.
// Assumes: One clock domain.
// Notes: Index counts interrupt sources from zero.
`timescale 1ns/1ps
`default_nettype none
interface vector_req_if;
   logic any;
   logic [5:0] index;
   modport enc (output any, output index);
   modport use_side (input any, input index);
endinterface : vector_req_if
`default_nettype wire

/* tb/core_fetch_model.sv */
// Purpose: Stands in for the core fetch logic that raises vector requests.
// Assumes: Requests are levels that the core holds until it changes them.
// Notes: Launches every change at the falling edge, clear of sampling.
`timescale 1ns/1ps
`default_nettype none
module core_fetch_model (
   input wire logic clk,
   input wire logic want_reset,
   input wire logic [33:0] want_irq,
   output logic reset_fetch_req,
   output logic [33:0] irq_pending
);
   initial begin
      reset_fetch_req = 1'b0;
      irq_pending = 34'h0;
   end
   always @(negedge clk) begin
      reset_fetch_req <= want_reset;
      irq_pending <= want_irq;
   end
endmodule : core_fetch_model
`default_nettype wire

/* tb/tb.sv */
// Purpose: Self-checking bench for the reset and interrupt vector mapper.
// Assumes: One registered cycle from request to vector, as handed over.
// Notes: Walks every source under all mode mixes, then random traffic.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b1, rst = 1'b1, fuse = 1'b1, sel = 1'b0, leg = 1'b0;
   logic [15:0] boot = 16'hf000;
   logic w_rst = 1'b0;
   logic [33:0] w_irq = 34'h0;
   logic req, v, isr;
   logic [33:0] pend;
   logic [5:0] num;
   logic [15:0] addr;
   int mismatches = 0, cmp_count = 0;
   always #10 clk = ~clk;
   core_fetch_model u_core (.clk(clk), .want_reset(w_rst), .want_irq(w_irq),
      .reset_fetch_req(req), .irq_pending(pend));
   reset_irq_vector_mapper u_dut (.clk(clk), .rst(rst),
      .boot_reset_fuse(fuse), .vector_table_boot_select(sel),
      .legacy_mode(leg), .boot_reset_addr(boot), .reset_fetch_req(req),
      .irq_pending(pend), .vec_valid(v), .vec_is_reset(isr),
      .vec_number(num), .vec_addr(addr));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      $display("mismatches %0d, compares %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out
   // Expected {valid, is_reset, number, address} from the vector table.
   function automatic logic [23:0] expect_vec(input logic rs, r,
         input logic [33:0] q, input logic f, s, l, input logic [15:0] b);
      logic [23:0] e;
      e = 24'h000000;
      for (int i = 33; i >= 0; i--) begin
         if (q[i] && !(l && i >= 23)) begin
            e = {2'b10, 6'(i + 2), (s ? b : 16'h0000) + 16'(2 * (i + 1))};
         end
      end
      if (rs | r) begin
         e = {2'b11, 6'h01, f ? 16'h0000 : b};
      end
      return e;
   endfunction : expect_vec
   // Applies one set of inputs at the falling edge, checks 2 ns after the next rising edge.
   task automatic apply(input logic rs, r, input logic [33:0] q,
         input logic f, s, l, input logic [15:0] b);
      logic ev, er;
      logic [5:0] en;
      logic [15:0] ea;
      {ev, er, en, ea} = expect_vec(rs, r, q, f, s, l, b);
      w_rst = r;
      w_irq = q;
      @(negedge clk);
      rst = rs;
      fuse = f;
      sel = s;
      leg = l;
      boot = b;
      @(posedge clk);
      #2;
      check(16'(v), 16'(ev));
      check(16'(isr), 16'(er));
      check(16'(num), 16'(en));
      check(addr, ea);
   endtask : apply
   initial begin
      void'($urandom(96282));
      repeat (5) apply(1'b1, 1'b0, 34'h1, 1'b1, 1'b0, 1'b0, 16'hf000);
      apply(1'b1, 1'b0, 34'h0, 1'b0, 1'b1, 1'b0, 16'he000);
      apply(1'b0, 1'b0, 34'h0, 1'b1, 1'b1, 1'b0, 16'he000);
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 34; i++) begin
            apply(1'b0, 1'b0, 34'h1 << i, k[0], k[1], k[2], 16'hf000);
         end
         apply(1'b0, 1'b1, 34'h3ffffffff, k[0], k[1], k[2], 16'hc000);
      end
      repeat (400) begin
         apply(($urandom % 40) == 0, ($urandom % 8) == 0,
            34'({$urandom, $urandom} & {$urandom, $urandom}),
            1'($urandom), 1'($urandom), 1'($urandom), 16'($urandom));
      end
      close_out();
   end
endmodule : tb
`default_nettype wire
